// File: core/motion_cmd_defs.svh
// Constants for the motion mode command interpreter.
// Assumes inclusion by bare name from the top module and the bench.
`ifndef MOTION_CMD_DEFS_SVH
`define MOTION_CMD_DEFS_SVH
`define OP_TORQUE_IN 8'hDA
`define OP_VEL_IN 8'hD9
`define OP_PROG_VEL 8'h9F
`define OP_REG_ABS_TIME 8'hEC
`define OP_REG_ABS_VEL 8'hEA
`define WORDS_SHORT 4'h4
`define WORDS_PROG_VEL 4'h7
`define INMODE_REG_FIRST 16'h000C
`define INMODE_REG_LAST 16'h0012
`define FETCH_COUNT 2'h3
`define FETCH_LAST 2'h2
`define FILT_ONE 17'h08000
`define FILT_K_MAX 16'h7FFF
`define FILT_SHIFT 15
`define FILT_UPDATE_US 120
`define CLK_MHZ 200
`define TICK_CYC (`FILT_UPDATE_US * `CLK_MHZ)
`endif

// File: core/motion_cmd_pkg.sv
// Types shared by the motion mode command interpreter and its bench.
// Assumes motion_cmd_defs.svh holds the numeric constants.
package motion_cmd_pkg;
    // Active mode; one-hot codes
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_TORQUE = 6'h02,
        ST_VELIN = 6'h04,
        ST_VRAMP = 6'h08,
        ST_FETCH = 6'h10,
        ST_MOVE = 6'h20
    } mode_t;
    typedef enum logic [1:0] {
        RSP_ACK = 2'h0,
        RSP_NAK_BUSY = 2'h1,
        RSP_NAK_BAD = 2'h2
    } rsp_t;
    // One framed command; w[0] is the first word after the opcode
    typedef struct packed {
        logic [7:0] opcode;
        logic [3:0] words;
        logic [5:0][15:0] w;
    } cmd_t;
    typedef struct packed {
        logic time_based;
        logic [31:0] pos;
        logic [31:0] p1;
        logic [31:0] p2;
        logic [15:0] stop_en;
        logic [15:0] stop_st;
    } move_t;
endpackage : motion_cmd_pkg

// File: core/servo_motion_mode_commands.sv
// Interpreter for the input modes, program velocity and register moves.
// Assumes a user register read port with one cycle of latency and an
// external profile engine that runs absolute moves and reports done.
// Function
// - Torque command enters torque mode using registers 12-18
// - Velocity input command enters velocity mode, registers 12-18
// - Velocity input: opcode 217, four words, filter/stop
// - Filter constant sets first-order filter, 120us update
// - Program velocity ramps to velocity at acceleration
// - In program, motion completes when velocity reaches zero
// - Stop condition met: ramp to zero, end motion
// - Serial command while busy gets busy NAK
// - Multi-tasking: replace motion at once, zero stops
// - Program velocity: opcode 159, seven words
// - Register moves fetch position and two parameters N..N+2
// - Register time move, opcode 236, like time move
// - Register velocity move, opcode 234, like velocity move
`timescale 1ns/10ps
`include "motion_cmd_defs.svh"
module servo_motion_mode_commands #(
    parameter int TICK_CYCLES = `TICK_CYC,
    parameter int IW = 16
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Command port
    input wire logic CMD_VALID,
    input wire motion_cmd_pkg::cmd_t CMD,
    input wire logic CMD_FROM_PROG,
    input wire logic PROG_RUNNING,
    input wire logic MULTI_TASK,
    // Response
    output logic RSP_VALID,
    output motion_cmd_pkg::rsp_t RSP_CODE,
    // Input pins for stop conditions
    input wire logic [IW-1:0] IN_PINS,
    // User register read port
    output logic REG_RD_EN,
    output logic [15:0] REG_RD_IDX,
    input wire logic [31:0] REG_RD_DATA,
    // Mode outputs
    output motion_cmd_pkg::mode_t MODE,
    output logic [15:0] FILTER_K,
    output logic [31:0] FILT_OUT,
    output logic [15:0] INMODE_IDX,
    output logic [31:0] INMODE_DATA,
    output logic [31:0] VEL_CMD,
    // Profile engine
    output logic MOVE_START,
    output motion_cmd_pkg::move_t MOVE,
    output logic MOVE_STOP,
    input wire logic MOVE_DONE
);
    import motion_cmd_pkg::*;

    mode_t state_q;
    logic [IW-1:0] in_s1_q, in_s2_q;
    logic [15:0] stop_en_q, stop_st_q;
    logic rsp_valid_q;
    rsp_t rsp_code_q;
    logic rd_en_q, cap_q;
    logic [15:0] rd_idx_q, cap_idx_q, base_q;
    logic [1:0] fcnt_q;
    logic [31:0] par0_q, par1_q;
    logic time_q;
    logic [15:0] k_q;
    logic signed [31:0] x_q, y_q, vel_q, tgt_q;
    logic [31:0] acc_q;
    logic stopping_q;
    logic [31:0] tick_cnt_q;
    logic tick;
    logic move_start_q, move_stop_q;
    move_t move_q;
    logic known, wc_ok, busy_rej, accept, stop_hit, ramp_end, fetch_last;
    logic signed [32:0] diff;
    logic signed [33:0] err;
    logic signed [51:0] prod;
    logic [16:0] gain;

    // Pins are asynchronous to CLK
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            in_s1_q <= '0;
            in_s2_q <= '0;
        end else begin
            in_s1_q <= IN_PINS;
            in_s2_q <= in_s1_q;
        end
    end

    // An all-zero enable mask never ends a mode
    assign stop_hit = (stop_en_q != 16'h0000) &&
        ((in_s2_q[15:0] & stop_en_q) == (stop_st_q & stop_en_q));

    always_comb begin
        known = 1'b1;
        wc_ok = (CMD.words == `WORDS_SHORT);
        if (CMD.opcode == `OP_PROG_VEL) begin
            wc_ok = (CMD.words == `WORDS_PROG_VEL);
        end else if (CMD.opcode == `OP_VEL_IN) begin
            wc_ok = (CMD.words == `WORDS_SHORT);
        end else if (CMD.opcode != `OP_TORQUE_IN &&
                     CMD.opcode != `OP_REG_ABS_TIME &&
                     CMD.opcode != `OP_REG_ABS_VEL) begin
            known = 1'b0;
        end
    end

    // Only a program task with multi-tasking may take over motion
    assign busy_rej = (state_q != ST_IDLE) ? !(CMD_FROM_PROG && MULTI_TASK)
        : (!CMD_FROM_PROG && PROG_RUNNING);
    assign accept = CMD_VALID && known && wc_ok && !busy_rej;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rsp_valid_q <= 1'b0;
            rsp_code_q <= RSP_ACK;
        end else begin
            rsp_valid_q <= CMD_VALID;
            // Code holds between commands so a late reader still sees it
            if (!CMD_VALID) begin
                rsp_code_q <= rsp_code_q;
            end else if (!known || !wc_ok) begin
                rsp_code_q <= RSP_NAK_BAD;
            end else if (busy_rej) begin
                rsp_code_q <= RSP_NAK_BUSY;
            end else begin
                rsp_code_q <= RSP_ACK;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end
    assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

    assign ramp_end = (vel_q == 32'sh0) && (stopping_q || tgt_q == 32'sh0);
    assign fetch_last = cap_q && (state_q == ST_FETCH) &&
        (cap_idx_q == base_q + 16'(`FETCH_LAST));

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
        end else if (accept) begin
            case (CMD.opcode)
                `OP_TORQUE_IN: state_q <= ST_TORQUE;
                `OP_VEL_IN: state_q <= ST_VELIN;
                `OP_PROG_VEL: state_q <= ST_VRAMP;
                default: state_q <= ST_FETCH;
            endcase
        end else begin
            case (state_q)
                ST_TORQUE, ST_VELIN: begin
                    if (stop_hit) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_VRAMP: begin
                    if (ramp_end) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_FETCH: begin
                    if (fetch_last) begin
                        state_q <= ST_MOVE;
                    end
                end
                ST_MOVE: begin
                    if (MOVE_DONE) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Command parameters captured on acceptance
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            stop_en_q <= '0;
            stop_st_q <= '0;
            k_q <= '0;
            acc_q <= '0;
            tgt_q <= '0;
            base_q <= '0;
            time_q <= 1'b0;
        end else if (accept) begin
            if (CMD.opcode == `OP_PROG_VEL) begin
                acc_q <= {CMD.w[0], CMD.w[1]};
                tgt_q <= {CMD.w[2], CMD.w[3]};
                stop_en_q <= CMD.w[4];
                stop_st_q <= CMD.w[5];
            end else begin
                stop_en_q <= CMD.w[1];
                stop_st_q <= CMD.w[2];
            end
            if (CMD.opcode == `OP_TORQUE_IN || CMD.opcode == `OP_VEL_IN) begin
                // Negative constants clamp to zero, i.e. no smoothing
                k_q <= CMD.w[0][15] ? 16'h0000 : CMD.w[0];
            end
            base_q <= CMD.w[0];
            time_q <= (CMD.opcode == `OP_REG_ABS_TIME);
        end
    end

    // Shared read port: scan 12..18 in input modes, fetch N..N+2 for moves
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_en_q <= 1'b0;
            rd_idx_q <= '0;
            fcnt_q <= '0;
            cap_q <= 1'b0;
            cap_idx_q <= '0;
        end else begin
            cap_q <= rd_en_q;
            cap_idx_q <= rd_idx_q;
            if (accept) begin
                rd_en_q <= 1'b0;
                fcnt_q <= '0;
                rd_idx_q <= `INMODE_REG_FIRST;
            end else if (state_q == ST_TORQUE || state_q == ST_VELIN) begin
                rd_en_q <= 1'b1;
                if (!rd_en_q || rd_idx_q >= `INMODE_REG_LAST) begin
                    rd_idx_q <= `INMODE_REG_FIRST;
                end else begin
                    rd_idx_q <= rd_idx_q + 16'h1;
                end
            end else if (state_q == ST_FETCH && fcnt_q < `FETCH_COUNT) begin
                rd_en_q <= 1'b1;
                rd_idx_q <= base_q + 16'(fcnt_q);
                fcnt_q <= fcnt_q + 2'h1;
            end else begin
                rd_en_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            par0_q <= '0;
            par1_q <= '0;
            x_q <= '0;
            INMODE_IDX <= '0;
            INMODE_DATA <= '0;
        end else if (cap_q) begin
            if (state_q == ST_FETCH) begin
                if (cap_idx_q == base_q) begin
                    par0_q <= REG_RD_DATA;
                end else if (cap_idx_q == base_q + 16'h1) begin
                    par1_q <= REG_RD_DATA;
                end
            end else begin
                INMODE_IDX <= cap_idx_q;
                INMODE_DATA <= REG_RD_DATA;
                if (cap_idx_q == `INMODE_REG_FIRST) begin
                    x_q <= REG_RD_DATA;
                end
            end
        end
    end

    // y += (x - y) * (1 - k/32768) once per update interval
    assign gain = `FILT_ONE - {1'b0, k_q};
    assign err = 34'(x_q) - 34'(y_q);
    assign prod = 52'(err) * $signed({35'h0, gain});
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            y_q <= '0;
        end else if (accept) begin
            y_q <= '0;
        end else if (tick && (state_q == ST_TORQUE || state_q == ST_VELIN)) begin
            y_q <= y_q + prod[`FILT_SHIFT +: 32];
        end
    end

    assign diff = 33'(stopping_q ? 32'sh0 : tgt_q) - 33'(vel_q);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            vel_q <= '0;
            stopping_q <= 1'b0;
        end else if (state_q != ST_VRAMP) begin
            // A takeover from another mode ramps from rest; the move engine holds its own speed
            vel_q <= '0;
            stopping_q <= 1'b0;
        end else if (accept) begin
            stopping_q <= 1'b0;
        end else begin
            if (stop_hit && tgt_q != 32'sh0) begin
                stopping_q <= 1'b1;
            end
            if (tick) begin
                if (diff > $signed({1'b0, acc_q})) begin
                    vel_q <= vel_q + $signed(acc_q);
                end else if (diff < -$signed({1'b0, acc_q})) begin
                    vel_q <= vel_q - $signed(acc_q);
                end else begin
                    vel_q <= vel_q + diff[31:0];
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            move_start_q <= 1'b0;
            move_stop_q <= 1'b0;
            move_q <= '0;
        end else begin
            move_start_q <= fetch_last;
            if (fetch_last) begin
                move_q <= '{time_q, par0_q, par1_q, REG_RD_DATA,
                    stop_en_q, stop_st_q};
            end
            // A takeover or a met stop condition abandons the move
            move_stop_q <= (state_q == ST_MOVE) && !MOVE_DONE &&
                (stop_hit || accept || move_stop_q);
        end
    end

    assign RSP_VALID = rsp_valid_q;
    assign RSP_CODE = rsp_code_q;
    assign REG_RD_EN = rd_en_q;
    assign REG_RD_IDX = rd_idx_q;
    assign MODE = state_q;
    assign FILTER_K = k_q;
    assign FILT_OUT = y_q;
    assign VEL_CMD = vel_q;
    assign MOVE_START = move_start_q;
    assign MOVE = move_q;
    assign MOVE_STOP = move_stop_q;

    AST_ACK: assert property (@(posedge CLK) disable iff (!RST_N)
        accept |=> RSP_VALID && RSP_CODE == RSP_ACK)
        else $error("accepted command not acknowledged");
    AST_BUSY: assert property (@(posedge CLK) disable iff (!RST_N)
        CMD_VALID && known && wc_ok && !CMD_FROM_PROG && PROG_RUNNING
        |=> RSP_CODE == RSP_NAK_BUSY && $stable(MODE))
        else $error("serial command during program not refused");
    AST_TORQUE: assert property (@(posedge CLK) disable iff (!RST_N)
        accept && CMD.opcode == `OP_TORQUE_IN |=> MODE == ST_TORQUE
        ##1 REG_RD_EN && REG_RD_IDX == `INMODE_REG_FIRST)
        else $error("torque mode did not start scanning");
    AST_SCAN: assert property (@(posedge CLK) disable iff (!RST_N)
        MODE == ST_VELIN && REG_RD_EN |-> REG_RD_IDX >= `INMODE_REG_FIRST
        && REG_RD_IDX <= `INMODE_REG_LAST)
        else $error("input mode read outside 12..18");
    AST_WORDS: assert property (@(posedge CLK) disable iff (!RST_N)
        CMD_VALID && CMD.opcode == `OP_VEL_IN && CMD.words != `WORDS_SHORT
        |=> RSP_CODE == RSP_NAK_BAD)
        else $error("bad word count accepted");
    AST_FILTK: assert property (@(posedge CLK) disable iff (!RST_N)
        FILTER_K <= `FILT_K_MAX)
        else $error("filter constant out of range");
    AST_RAMP: assert property (@(posedge CLK) disable iff (!RST_N)
        MODE == ST_VRAMP && tick && !accept |=>
        (VEL_CMD - $past(VEL_CMD) <= $past(acc_q)) ||
        ($past(VEL_CMD) - VEL_CMD <= $past(acc_q)))
        else $error("velocity step exceeds acceleration");
    AST_END: assert property (@(posedge CLK) disable iff (!RST_N)
        MODE == ST_VRAMP && ramp_end && !accept |=> MODE == ST_IDLE)
        else $error("ramp did not end at zero velocity");
    AST_STOP: assert property (@(posedge CLK) disable iff (!RST_N)
        MODE == ST_VRAMP && stop_hit && tgt_q != 32'sh0 && !accept
        |=> stopping_q)
        else $error("stop condition ignored in velocity ramp");
    AST_TAKE: assert property (@(posedge CLK) disable iff (!RST_N)
        accept && MODE == ST_MOVE && !MOVE_DONE && CMD.opcode == `OP_PROG_VEL
        |=> MOVE_STOP && MODE == ST_VRAMP)
        else $error("takeover did not abandon move");
    AST_FETCH: assert property (@(posedge CLK) disable iff (!RST_N)
        accept && CMD.opcode == `OP_REG_ABS_TIME |-> ##6 MOVE_START
        && MOVE.time_based)
        else $error("register time move not started");
    AST_MASK: assert property (@(posedge CLK) disable iff (!RST_N)
        MODE == ST_TORQUE && stop_hit && !accept |=> MODE == ST_IDLE)
        else $error("input mode not ended by stop match");
endmodule : servo_motion_mode_commands

// File: verif/motion_far_model.sv
// Far-side model: user register file and absolute move profile engine.
// Assumes a one-cycle read latency and a fixed move duration.
`timescale 1ns/10ps
module motion_far_model #(
    parameter int DONE_DLY = 5
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // User register read
    input wire logic REG_RD_EN,
    input wire logic [15:0] REG_RD_IDX,
    output logic [31:0] REG_RD_DATA,
    // Profile engine
    input wire logic MOVE_START,
    output logic MOVE_DONE
);
    int cnt_q;
    // Data is inverted each cycle when not read, so a stale value matches the last read every second cycle
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            REG_RD_DATA <= 32'h0;
        else if (REG_RD_EN)
            REG_RD_DATA <= {REG_RD_IDX ^ 16'h5A5A, REG_RD_IDX};
        else
            REG_RD_DATA <= ~REG_RD_DATA;
    end
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q <= 0;
            MOVE_DONE <= 1'b0;
        end else begin
            MOVE_DONE <= (cnt_q == 1);
            if (MOVE_START)
                cnt_q <= DONE_DLY;
            else if (cnt_q != 0)
                cnt_q <= cnt_q - 1;
        end
    end
endmodule : motion_far_model

// File: verif/servo_motion_mode_commands_tb.sv
// Self-checking bench for the motion mode command interpreter.
// Assumes the far model answers reads and ends moves after a few cycles.
`timescale 1ns/10ps
`include "motion_cmd_defs.svh"
module servo_motion_mode_commands_tb;
    import motion_cmd_pkg::*;
    localparam int TK = 4;
    localparam int S = 4;
    typedef struct {
        cmd_t c;
        logic fp;
        logic pr;
        rsp_t r;
        mode_t m;
    } row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    cmd_t cmd = '0;
    logic cmd_from_prog = 1'b0;
    logic prog_running = 1'b0;
    logic multi_task = 1'b0;
    logic [15:0] in_pins = 16'h0;
    logic rsp_valid, reg_rd_en, move_start, move_stop, move_done;
    rsp_t rsp_code;
    mode_t mode;
    logic [15:0] reg_rd_idx, filter_k, inmode_idx;
    logic [31:0] reg_rd_data, filt_out, inmode_data, vel_cmd;
    move_t move;
    int fail_count = 0;
    int num_checks = 0;
    int up[4] = '{3, 6, 9, 10};
    int dn[4] = '{7, 4, 1, 0};
    row_t rows[10];

    always #2.5 clk = ~clk;

    servo_motion_mode_commands #(.TICK_CYCLES(TK), .IW(16))
        i_servo_motion_mode_commands (
        .CLK(clk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD(cmd),
        .CMD_FROM_PROG(cmd_from_prog), .PROG_RUNNING(prog_running),
        .MULTI_TASK(multi_task), .RSP_VALID(rsp_valid),
        .RSP_CODE(rsp_code), .IN_PINS(in_pins), .REG_RD_EN(reg_rd_en),
        .REG_RD_IDX(reg_rd_idx), .REG_RD_DATA(reg_rd_data), .MODE(mode),
        .FILTER_K(filter_k), .FILT_OUT(filt_out), .INMODE_IDX(inmode_idx),
        .INMODE_DATA(inmode_data), .VEL_CMD(vel_cmd),
        .MOVE_START(move_start), .MOVE(move), .MOVE_STOP(move_stop),
        .MOVE_DONE(move_done));

    motion_far_model #(.DONE_DLY(5)) i_motion_far_model (
        .CLK(clk), .RST_N(rst_n), .REG_RD_EN(reg_rd_en),
        .REG_RD_IDX(reg_rd_idx), .REG_RD_DATA(reg_rd_data),
        .MOVE_START(move_start), .MOVE_DONE(move_done));

    function automatic cmd_t mk(input int op, n, a, b, c, d = 0, e = 0,
            f = 0);
        return '{8'(op), 4'(n), {16'(f), 16'(e), 16'(d), 16'(c), 16'(b),
            16'(a)}};
    endfunction : mk

    // Wide fields go high word first
    function automatic cmd_t program_velocity_move_cmd(input int acc, vel, en, st);
        return mk(`OP_PROG_VEL, 7, acc >> 16, acc, vel >> 16, vel, en, st);
    endfunction : program_velocity_move_cmd

    function automatic logic [31:0] ereg(input int x);
        return {16'(x) ^ 16'h5A5A, 16'(x)};
    endfunction : ereg

    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic send(input cmd_t c, input logic fp);
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd = c;
        cmd_from_prog = fp;
        cyc(1);
        cmd_valid = 1'b0;
    endtask : send

    // Bounded waits end the run on expiry rather than hang
    task automatic wait_mode(input mode_t m, input int n);
        for (int k = 0; k < n && mode !== m; k++) cyc(1);
        chk(mode, m);
        if (mode !== m) finish_test();
    endtask : wait_mode

    task automatic wait_vel(input int e);
        logic [31:0] old;
        old = vel_cmd;
        for (int k = 0; k < 3 * TK && vel_cmd === old; k++) cyc(1);
        chk(vel_cmd, e);
        if (vel_cmd === old) finish_test();
    endtask : wait_vel

    initial begin
        rows = '{
            '{mk(`OP_TORQUE_IN, S, 0, 1, 0), 0, 0, RSP_ACK, ST_TORQUE},
            '{mk(`OP_VEL_IN, S, 0, 1, 0), 0, 0, RSP_ACK, ST_VELIN},
            '{program_velocity_move_cmd(1, 0, 0, 0), 0, 0, RSP_ACK, ST_VRAMP},
            '{mk(`OP_REG_ABS_TIME, S, 30, 0, 0), 0, 0, RSP_ACK, ST_FETCH},
            '{mk(`OP_REG_ABS_VEL, S, 30, 0, 0), 0, 0, RSP_ACK, ST_FETCH},
            '{mk(`OP_PROG_VEL, S, 0, 1, 0), 0, 0, RSP_NAK_BAD, ST_IDLE},
            '{mk(`OP_VEL_IN, 7, 0, 1, 0), 0, 0, RSP_NAK_BAD, ST_IDLE},
            '{mk(0, S, 0, 1, 0), 0, 0, RSP_NAK_BAD, ST_IDLE},
            '{mk(`OP_TORQUE_IN, S, 0, 1, 0), 0, 1, RSP_NAK_BUSY, ST_IDLE},
            '{mk(`OP_TORQUE_IN, S, 0, 1, 0), 1, 1, RSP_ACK, ST_TORQUE}};
        cyc(2);
        rst_n = 1'b1;
        chk(mode, ST_IDLE);
        chk({rsp_valid, reg_rd_en, move_start}, 0);
        chk(vel_cmd, 0);
        foreach (rows[i]) begin
            prog_running = rows[i].pr;
            send(rows[i].c, rows[i].fp);
            chk(rsp_valid, 1);
            chk(rsp_code, rows[i].r);
            chk(mode, rows[i].m);
            wait_mode(ST_IDLE, 40);
        end
        $display("Test done: command table");
        prog_running = 1'b0;
        send(mk(`OP_TORQUE_IN, S, 0, 1, 1), 1'b0);
        cyc(1);
        for (int i = 0; i < 9; i++) begin
            chk(reg_rd_idx, 12 + i % 7);
            if (i >= 2) chk(inmode_data, ereg(12 + (i - 2) % 7));
            if (i >= 2) chk(inmode_idx, 12 + (i - 2) % 7);
            cyc(1);
        end
        prog_running = 1'b1;
        send(program_velocity_move_cmd(3, 10, 2, 2), 1'b0);
        chk(rsp_code, RSP_NAK_BUSY);
        chk(mode, ST_TORQUE);
        multi_task = 1'b1;
        send(program_velocity_move_cmd(3, 10, 2, 2), 1'b1);
        chk(mode, ST_VRAMP);
        foreach (up[j]) wait_vel(up[j]);
        in_pins = 16'h2;
        foreach (dn[j]) begin
            chk(mode, ST_VRAMP);
            wait_vel(dn[j]);
        end
        wait_mode(ST_IDLE, 3);
        $display("Test done: scan, busy and ramp");
        prog_running = 1'b0;
        multi_task = 1'b0;
        in_pins = 16'h4;
        for (int t = 0; t < 2; t++) begin
            send(mk(t ? `OP_REG_ABS_VEL : `OP_REG_ABS_TIME, S, 30, 4, 4), 0);
            chk(mode, ST_FETCH);
            for (int r = 0; r < 3; r++) begin
                cyc(1);
                chk(reg_rd_idx, 30 + r);
            end
            cyc(2);
            chk(move_start, 1);
            chk(move.time_based, t == 0);
            chk(move.pos, ereg(30));
            chk(move.p1, ereg(31));
            chk(move.p2, ereg(32));
            chk({move.stop_en, move.stop_st}, 32'h00040004);
            cyc(2);
            chk(move_stop, 1);
            wait_mode(ST_IDLE, 12);
        end
        // A program velocity command takes over a running move
        send(mk(`OP_REG_ABS_VEL, S, 30, 0, 0), 1'b0);
        wait_mode(ST_MOVE, 8);
        multi_task = 1'b1;
        send(program_velocity_move_cmd(1, 0, 0, 0), 1'b1);
        chk({mode, move_stop}, {ST_VRAMP, 1'b1});
        wait_mode(ST_IDLE, 3);
        $display("Test done: register moves");
        in_pins = 16'h0;
        send(mk(`OP_VEL_IN, S, 16'h7FFF, 0, 0), 1'b0);
        cyc(1);
        chk(filter_k, 16'h7FFF);
        multi_task = 1'b1;
        send(mk(`OP_VEL_IN, S, 16'hFFFF, 0, 0), 1'b1);
        cyc(1);
        chk(filter_k, 0);
        cyc(3 * TK + 4);
        chk(filt_out, ereg(12));
        send(program_velocity_move_cmd(1, 0, 0, 0), 1'b1);
        wait_mode(ST_IDLE, 3);
        chk(vel_cmd, 0);
        $display("Test done: filter and shutdown");
        send(mk(`OP_TORQUE_IN, S, 0, 1, 1), 1'b0);
        cyc(2);
        rst_n = 1'b0;
        #1;
        chk(mode, ST_IDLE);
        chk(reg_rd_en, 0);
        cyc(2);
        rst_n = 1'b1;
        send(mk(`OP_TORQUE_IN, S, 0, 1, 1), 1'b0);
        chk(rsp_code, RSP_ACK);
        $display("Test done: reset");
        finish_test();
    end
endmodule : servo_motion_mode_commands_tb
